/* File: tb/sdcp_pin_ctrl_asserts.sv */
// Port checks for the SDRAM command pin driver
`timescale 1ns/1ns
`default_nettype none
module sdcp_pin_ctrl_asserts #(
    parameter int WAKE_CYCLES = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic busOwner,
    input wire logic busIs32,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire sdcp_pkg::sdcp_req_t cmdReq,
    input wire sdcp_pkg::sdcp_pins_t sdramPinsOut,
    input wire logic sdramPinsOe,
    input wire logic host_request_n,
    input wire logic host_grant_n_out,
    input wire logic host_grant_n_oe,
    input wire logic hostGranted
);
    import sdcp_pkg::*;
    sdcp_req_t reqQ_reg;
    logic is32Q_reg;
    wire logic take = cmdValid && cmdReady;
    wire logic inWin = cmdReq.address[31:26] == 6'h01;
    // Copies of the taken request, so mask checks see its fields
    always_ff @(posedge sys_clk) begin
        reqQ_reg <= cmdReq;
        is32Q_reg <= busIs32;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence selfRefreshPins;
        sdramPinsOe && !sdramPinsOut.memSelN && !sdramPinsOut.rasN && !sdramPinsOut.casN && !sdramPinsOut.clkEnable;
    endsequence
    sequence pinsReleased;
        !sdramPinsOe && !host_grant_n_out && hostGranted;
    endsequence
    AST_WRITE: assert property (take && inWin && cmdReq.cmd == CMD_WRITE |=>
        !sdramPinsOut.memSelN && sdramPinsOut.rasN && !sdramPinsOut.casN && !sdramPinsOut.writeEnableN)
        else $error("write strobes wrong");
    AST_MASKS: assert property (take && inWin && cmdReq.cmd == CMD_WRITE |=>
        sdramPinsOut.lowWordMask == (!is32Q_reg && reqQ_reg.address[0]) && sdramPinsOut.highWordMask
        == (is32Q_reg || (reqQ_reg.wordAccess && !reqQ_reg.address[0]))) else $error("write masks wrong");
    AST_READ: assert property (take && inWin && cmdReq.cmd == CMD_READ |=>
        !sdramPinsOut.casN && sdramPinsOut.writeEnableN && !sdramPinsOut.lowWordMask
        && !sdramPinsOut.highWordMask) else $error("read strobes wrong");
    AST_ACTIVE: assert property (take && inWin && cmdReq.cmd == CMD_ACTIVE |=>
        !sdramPinsOut.rasN && sdramPinsOut.casN) else $error("row strobe wrong");
    AST_OUTWIN: assert property (take && !inWin && cmdReq.cmd inside {CMD_READ, CMD_WRITE} |=>
        sdramPinsOut.memSelN) else $error("select outside window");
    AST_IDLE_MASK: assert property (sdramPinsOut.casN |->
        !sdramPinsOut.lowWordMask && !sdramPinsOut.highWordMask) else $error("mask without column strobe");
    AST_REFRESH: assert property (take && cmdReq.cmd == CMD_REFRESH |=> !sdramPinsOut.rasN
        && !sdramPinsOut.casN && sdramPinsOut.writeEnableN && $stable(sdramPinsOut.refreshAddrBit10))
        else $error("refresh encoding wrong");
    AST_CKE: assert property (take && cmdReq.cmd inside {CMD_SELF_ENTER, CMD_SUSPEND_ENTER} |=>
        !sdramPinsOut.clkEnable) else $error("clock enable not dropped");
    AST_OWNER: assert property (!busOwner |-> !cmdReady ##1 (!host_grant_n_oe && !sdramPinsOe))
        else $error("non owner drives");
    AST_GRANT: assert property ($fell(host_request_n) && busOwner && cmdReady |->
        ##[1:8] selfRefreshPins ##1 pinsReleased) else $error("grant sequence wrong");
    AST_RESET: assert property (@(posedge sys_clk) disable iff (1'b0) !reset_n |=>
        sdramPinsOut == 8'hF1 && !sdramPinsOe && host_grant_n_out) else $error("reset levels wrong");
endmodule : sdcp_pin_ctrl_asserts
bind sdcp_pin_ctrl sdcp_pin_ctrl_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .busOwner(busOwner), .busIs32(busIs32), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdReq(cmdReq),
    .sdramPinsOut(sdramPinsOut), .sdramPinsOe(sdramPinsOe), .host_request_n(host_request_n),
    .host_grant_n_out(host_grant_n_out), .host_grant_n_oe(host_grant_n_oe), .hostGranted(hostGranted));
`default_nettype wire

/* File: tb/sdcp_pin_ctrl_tb.sv */
// Self-checking bench for the SDRAM command pin driver
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) check(32'(g), 32'(e), m)
module sdcp_pin_ctrl_tb;
    import sdcp_pkg::*;
    logic sys_clk, reset_n, busOwner, busIs32, cmdValid, host_request_n;
    logic cmdReady, sdramPinsOe, host_grant_n_out, host_grant_n_oe, hostGranted;
    sdcp_req_t cmdReq;
    sdcp_pins_t pins;
    logic [2:0] lastCode;
    logic [1:0] laneWritten;
    int n_errors = 0;
    int tests_run = 0;
    sdcp_pin_ctrl #(.WAKE_CYCLES(1)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .busOwner(busOwner),
        .busIs32(busIs32), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdReq(cmdReq), .sdramPinsOut(pins),
        .sdramPinsOe(sdramPinsOe), .host_request_n(host_request_n), .host_grant_n_out(host_grant_n_out),
        .host_grant_n_oe(host_grant_n_oe), .hostGranted(hostGranted));
    sdcp_sdram_model mem (.sys_clk(sys_clk), .pinsIn(pins), .pinsOe(sdramPinsOe), .lastCode(lastCode),
        .laneWritten(laneWritten));
    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // Request raised after an edge, held until the edge that takes it
    task automatic send(input sdcp_cmd_t c, input logic [31:0] a, input logic a10, input logic w);
        int i;
        i = 0;
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdReq <= '{c, a, a10, w};
        @(negedge sys_clk);
        while (cmdReady !== 1'b1 && i < 20) begin
            @(negedge sys_clk);
            i++;
        end
        if (i >= 20) begin
            n_errors++;
            $display("wrong value at %0t ns: ready never came", $time);
        end
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        #1;
    endtask : send
    // Every width, parity and word size; masks and lanes
    task automatic t_write();
        logic [2:0] k;
        logic lo, hi;
        for (int j = 0; j < 8; j++) begin
            k = 3'(j);
            lo = !k[2] && k[1];
            hi = k[2] || (k[0] && !k[1]);
            @(posedge sys_clk);
            busIs32 <= k[2];
            send(CMD_WRITE, {6'h01, 25'h0, k[1]}, 1'b0, k[0]);
            `CHK(pins[7:2], {4'b0100, lo, hi}, "write pins");
            @(posedge sys_clk);
            #1;
            `CHK(pins[7:2], 6'h3C, "idle after write");
            `CHK(laneWritten, {!hi, !lo}, "lanes written");
        end
    endtask : t_write
    // Reads in and out of the window, then a row open
    task automatic t_read();
        send(CMD_READ, 32'h0400_0002, 1'b0, 1'b1);
        `CHK(pins[7:2], 6'h14, "read pins");
        send(CMD_READ, 32'h0800_0000, 1'b0, 1'b1);
        `CHK(pins.memSelN, 1'b1, "select outside window");
        send(CMD_ACTIVE, 32'h0400_0000, 1'b1, 1'b0);
        `CHK(pins[7:5], 3'b001, "row strobe");
    endtask : t_read
    // Remaining commands, with clock enable and address bit 10
    task automatic t_cmds();
        sdcp_cmd_t cl[8] = '{CMD_PRECHARGE, CMD_REFRESH, CMD_MODE, CMD_SELF_ENTER, CMD_SELF_EXIT,
            CMD_SUSPEND_ENTER, CMD_SUSPEND_EXIT, CMD_NOP};
        logic [3:0] el[8] = '{4'h5, 4'h3, 4'h1, 4'h2, 4'hF, 4'hE, 4'hF, 4'hF};
        // Bit 10 asked for and expected; only precharge and mode copy it, the rest hold
        logic [7:0] ai = 8'h06;
        logic [7:0] ea = 8'hFC;
        for (int i = 0; i < 8; i++) begin
            send(cl[i], 32'h0, ai[i], 1'b0);
            `CHK({pins[6:4], pins.clkEnable}, el[i], "command pins");
            `CHK(pins.refreshAddrBit10, ea[i], "address bit 10");
        end
    endtask : t_cmds
    // Losing bus ownership stops commands and grant drive
    task automatic t_owner();
        @(posedge sys_clk);
        busOwner <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK({cmdReady, host_grant_n_oe, sdramPinsOe}, 3'b000, "non owner");
        @(posedge sys_clk);
        busOwner <= 1'b1;
    endtask : t_owner
    // Host takes the bus: self-refresh, release, then wake
    task automatic t_host();
        int i;
        i = 0;
        // A read first, so the model's last code must change to self-refresh
        send(CMD_READ, 32'h0400_0000, 1'b0, 1'b1);
        @(posedge sys_clk);
        host_request_n <= 1'b0;
        while (hostGranted !== 1'b1 && i < 12) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        `CHK({hostGranted, sdramPinsOe, host_grant_n_out, cmdReady}, 4'h8, "grant");
        `CHK(lastCode, 3'b001, "self-refresh before grant");
        @(posedge sys_clk);
        host_request_n <= 1'b1;
        send(CMD_NOP, 32'h0, 1'b0, 1'b0);
        `CHK({host_grant_n_out, sdramPinsOe, pins.clkEnable}, 3'h7, "bus back");
    endtask : t_host
    // Main sequence
    initial begin
        reset_n = 1'b0;
        busOwner = 1'b1;
        busIs32 = 1'b0;
        cmdValid = 1'b0;
        cmdReq = '0;
        host_request_n = 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK({pins, sdramPinsOe}, 9'h1E2, "reset levels");
        @(posedge sys_clk);
        reset_n <= 1'b1;
        t_write();
        t_read();
        t_cmds();
        t_owner();
        t_host();
        tally_and_finish();
    end
    // Watchdog far past the fewer than a hundred cycles needed
    initial begin
        #(5000 * 8);
        n_errors++;
        tally_and_finish();
    end
endmodule : sdcp_pin_ctrl_tb
`default_nettype wire

/* File: tb/sdcp_sdram_model.sv */
// Behavioural SDRAM device watching the control pins
`timescale 1ns/1ns
`default_nettype none
module sdcp_sdram_model (
    input wire logic sys_clk,
    input wire sdcp_pkg::sdcp_pins_t pinsIn,
    input wire logic pinsOe,
    output logic [2:0] lastCode,
    output logic [1:0] laneWritten
);
    import sdcp_pkg::*;
    sdcp_pins_t lvl;
    // Released pins float to their pull-ups, so nothing is selected
    assign lvl = pinsOe ? pinsIn : 8'hFF;
    // Decode selected cycles; a high mask keeps its lane off the bus
    always_ff @(posedge sys_clk) begin
        if (!lvl.memSelN) begin
            lastCode <= {lvl.rasN, lvl.casN, lvl.writeEnableN};
            laneWritten <= (!lvl.casN && !lvl.writeEnableN) ? {!lvl.highWordMask, !lvl.lowWordMask} : 2'b00;
        end
    end
endmodule : sdcp_sdram_model
`default_nettype wire

/* File: verilog/sdcp_defines.svh */
// Constants for the SDRAM command pin control block
`ifndef SDCP_DEFINES_SVH
`define SDCP_DEFINES_SVH
// SDRAM window decode on the upper address bits
`define SDCP_WIN_HI 31
`define SDCP_WIN_LO 26
`define SDCP_WIN_MATCH 6'h01
// Strobe levels, all strobes active low
`define SDCP_STB_ON 1'b0
`define SDCP_STB_OFF 1'b1
// Mask levels, high blocks the lane
`define SDCP_MASK_ON 1'b1
`define SDCP_MASK_OFF 1'b0
// Clock enable levels
`define SDCP_CKE_RUN 1'b1
`define SDCP_CKE_STOP 1'b0
// Word parity bit of the address
`define SDCP_WORD_BIT 0
// Wake count width
`define SDCP_WAKE_W 8
`define SDCP_WAKE_ZERO 8'h00
`define SDCP_WAKE_ONE 8'h01
`endif

/* File: verilog/sdcp_pin_ctrl.sv */
// SDRAM command, mask, address bit 10 and clock enable pin driver
`timescale 1ns/1ns
`default_nettype none
`include "sdcp_defines.svh"

module sdcp_pin_ctrl #(
    parameter int WAKE_CYCLES = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic busOwner,
    input wire logic busIs32,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire sdcp_pkg::sdcp_req_t cmdReq,
    output sdcp_pkg::sdcp_pins_t sdramPinsOut,
    output logic sdramPinsOe,
    input wire logic host_request_n,
    output logic host_grant_n_out,
    output logic host_grant_n_oe,
    output logic hostGranted
);
    import sdcp_pkg::*;

    // Host handshake states
    typedef enum logic [1:0] {
        ST_OWN = 2'b00,
        ST_SELF = 2'b01,
        ST_HOST = 2'b10,
        ST_WAKE = 2'b11
    } sdcp_state_t;

    // Wake count load, cut to the counter width on purpose
    localparam logic [`SDCP_WAKE_W-1:0] WAKE_LOAD = WAKE_CYCLES[`SDCP_WAKE_W-1:0];

    // Pin value when nothing is issued
    localparam sdcp_pins_t PINS_IDLE = '{
        memSelN: `SDCP_STB_OFF,
        rasN: `SDCP_STB_OFF,
        casN: `SDCP_STB_OFF,
        writeEnableN: `SDCP_STB_OFF,
        lowWordMask: `SDCP_MASK_OFF,
        highWordMask: `SDCP_MASK_OFF,
        refreshAddrBit10: 1'b0,
        clkEnable: `SDCP_CKE_RUN
    };

    // Handshake state
    sdcp_state_t state_reg;
    sdcp_state_t state_next;
    // Pin group and its drive enable
    sdcp_pins_t pins_reg;
    sdcp_pins_t pins_next;
    logic pinsOe_reg;
    logic pinsOe_next;
    // Grant pin and its drive enable
    logic grant_reg;
    logic grant_next;
    logic grantOe_reg;
    logic grantOe_next;
    // Clock enable and wake counter
    logic cke_reg;
    logic cke_next;
    logic [`SDCP_WAKE_W-1:0] wakeCnt_reg;
    logic [`SDCP_WAKE_W-1:0] wakeCnt_next;
    // Request synchroniser and command decode
    logic hostReqMeta_reg;
    logic hostReqMeta_next;
    logic hostReqSync_reg;
    logic hostReqSync_next;
    logic hostWants;
    logic winHit;
    logic cmdFire;
    logic oddWord;

    // Request pin comes from the host, so two flops first
    always_comb begin
        hostReqMeta_next = host_request_n;
        hostReqSync_next = hostReqMeta_reg;
    end

    // Sync flops park at the idle level so no false request follows reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hostReqMeta_reg <= 1'b1;
            hostReqSync_reg <= 1'b1;
        end else begin
            hostReqMeta_reg <= hostReqMeta_next;
            hostReqSync_reg <= hostReqSync_next;
        end
    end

    assign hostWants = !hostReqSync_reg;

    // SDRAM window decode and address parity
    assign winHit = (cmdReq.address[`SDCP_WIN_HI:`SDCP_WIN_LO] == `SDCP_WIN_MATCH);
    assign oddWord = cmdReq.address[`SDCP_WORD_BIT];

    // A pending host request blocks new commands so self-refresh goes first
    assign cmdReady = (state_reg == ST_OWN) && busOwner && !hostWants;
    assign cmdFire = cmdValid && cmdReady;

    // Next-state and pin encoding
    always_comb begin
        // State, pin drive enable, grant and wake count hold; strobes and masks go idle, grant drive follows busOwner
        state_next = state_reg;
        pins_next = PINS_IDLE;
        // Clock enable and address bit 10 keep their last values
        pins_next.clkEnable = cke_reg;
        pins_next.refreshAddrBit10 = pins_reg.refreshAddrBit10;
        pinsOe_next = pinsOe_reg;
        grant_next = grant_reg;
        grantOe_next = busOwner;
        cke_next = cke_reg;
        wakeCnt_next = wakeCnt_reg;

        // Per-state behaviour
        case (state_reg)
            // Owner: self-refresh for a host first, else one command
            ST_OWN: begin
                pinsOe_next = busOwner;
                if (busOwner && hostWants) begin
                    // Self-refresh entry: refresh with clock enable dropped
                    pins_next.memSelN = `SDCP_STB_ON;
                    pins_next.rasN = `SDCP_STB_ON;
                    pins_next.casN = `SDCP_STB_ON;
                    pins_next.writeEnableN = `SDCP_STB_OFF;
                    cke_next = `SDCP_CKE_STOP;
                    pins_next.clkEnable = `SDCP_CKE_STOP;
                    state_next = ST_SELF;
                end else if (cmdFire) begin
                    case (cmdReq.cmd)
                        // Row open: row strobe only inside the window
                        CMD_ACTIVE: begin
                            if (winHit) begin
                                pins_next.memSelN = `SDCP_STB_ON;
                                pins_next.rasN = `SDCP_STB_ON;
                            end
                            pins_next.refreshAddrBit10 = cmdReq.addrBit10;
                        end

                        // Read: column strobe with write enable high
                        CMD_READ: begin
                            if (winHit) begin
                                pins_next.memSelN = `SDCP_STB_ON;
                                pins_next.casN = `SDCP_STB_ON;
                                pins_next.writeEnableN = `SDCP_STB_OFF;
                            end
                            // Masks stay low on reads
                            pins_next.refreshAddrBit10 = cmdReq.addrBit10;
                        end

                        // Write: column strobe, write enable low, lane masks
                        CMD_WRITE: begin
                            if (winHit) begin
                                pins_next.memSelN = `SDCP_STB_ON;
                                pins_next.casN = `SDCP_STB_ON;
                                pins_next.writeEnableN = `SDCP_STB_ON;
                                // Blocked lane is floated at the memory
                                pins_next.lowWordMask = (!busIs32 && oddWord);
                                pins_next.highWordMask =
                                    busIs32 || (cmdReq.wordAccess && !oddWord);
                            end
                            pins_next.refreshAddrBit10 = cmdReq.addrBit10;
                        end

                        // Precharge: bit 10 picks one bank or all
                        CMD_PRECHARGE: begin
                            pins_next.memSelN = `SDCP_STB_ON;
                            pins_next.rasN = `SDCP_STB_ON;
                            pins_next.writeEnableN = `SDCP_STB_ON;
                            pins_next.refreshAddrBit10 = cmdReq.addrBit10;
                        end

                        // Refresh: bit 10 is left as it was, the memory ignores it
                        CMD_REFRESH: begin
                            pins_next.memSelN = `SDCP_STB_ON;
                            pins_next.rasN = `SDCP_STB_ON;
                            pins_next.casN = `SDCP_STB_ON;
                        end

                        // Mode register load: all three strobes low
                        CMD_MODE: begin
                            pins_next.memSelN = `SDCP_STB_ON;
                            pins_next.rasN = `SDCP_STB_ON;
                            pins_next.casN = `SDCP_STB_ON;
                            pins_next.writeEnableN = `SDCP_STB_ON;
                            pins_next.refreshAddrBit10 = cmdReq.addrBit10;
                        end

                        // Self-refresh entry on request of the controller
                        CMD_SELF_ENTER: begin
                            pins_next.memSelN = `SDCP_STB_ON;
                            pins_next.rasN = `SDCP_STB_ON;
                            pins_next.casN = `SDCP_STB_ON;
                            cke_next = `SDCP_CKE_STOP;
                            pins_next.clkEnable = `SDCP_CKE_STOP;
                        end

                        // Clock enable moves alone for suspend
                        CMD_SUSPEND_ENTER: begin
                            // Suspend is a NOP with the clock enable dropped
                            cke_next = `SDCP_CKE_STOP;
                            pins_next.clkEnable = `SDCP_CKE_STOP;
                        end

                        // Exits: clock enable back up, strobes idle
                        CMD_SELF_EXIT, CMD_SUSPEND_EXIT: begin
                            cke_next = `SDCP_CKE_RUN;
                            pins_next.clkEnable = `SDCP_CKE_RUN;
                        end

                        // NOP and unused codes leave the pins idle
                        default: begin
                            pins_next.memSelN = `SDCP_STB_OFF;
                        end
                    endcase
                end
            end

            ST_SELF: begin
                // Let go of the pins and grant the bus in the cycle after entry, clock enable held low
                pinsOe_next = 1'b0;
                grant_next = 1'b0;
                state_next = ST_HOST;
            end

            ST_HOST: begin
                pinsOe_next = 1'b0;
                if (!hostWants) begin
                    // Host done: retake the pins and wake the memory
                    grant_next = 1'b1;
                    pinsOe_next = busOwner;
                    cke_next = `SDCP_CKE_RUN;
                    pins_next.clkEnable = `SDCP_CKE_RUN;
                    wakeCnt_next = WAKE_LOAD;
                    state_next = ST_WAKE;
                end
            end

            ST_WAKE: begin
                // NOPs while the memory leaves self-refresh
                pinsOe_next = busOwner;
                if (wakeCnt_reg <= `SDCP_WAKE_ONE) begin
                    wakeCnt_next = `SDCP_WAKE_ZERO;
                    state_next = ST_OWN;
                end else begin
                    wakeCnt_next = wakeCnt_reg - `SDCP_WAKE_ONE;
                end
            end

            // Unused state code falls back to the owner state
            default: begin
                state_next = ST_OWN;
            end
        endcase
    end

    // Registers; reset parks every pin but clock enable at its inactive level, and clock enable at run
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= ST_OWN;
            pins_reg <= PINS_IDLE;
            pinsOe_reg <= 1'b0;
            grant_reg <= 1'b1;
            grantOe_reg <= 1'b0;
            cke_reg <= `SDCP_CKE_RUN;
            wakeCnt_reg <= `SDCP_WAKE_ZERO;
        end else begin
            state_reg <= state_next;
            pins_reg <= pins_next;
            pinsOe_reg <= pinsOe_next;
            grant_reg <= grant_next;
            grantOe_reg <= grantOe_next;
            cke_reg <= cke_next;
            wakeCnt_reg <= wakeCnt_next;
        end
    end

    // Pins come straight from flops
    assign sdramPinsOut = pins_reg;
    assign sdramPinsOe = pinsOe_reg;

    // Grant pin from flops; status follows the state flop
    assign host_grant_n_out = grant_reg;
    assign host_grant_n_oe = grantOe_reg;
    assign hostGranted = (state_reg == ST_HOST);
endmodule : sdcp_pin_ctrl
`default_nettype wire

/* File: verilog/sdcp_pkg.sv */
// Types for the SDRAM command pin control block
`default_nettype none
package sdcp_pkg;
    // Commands offered by the memory controller
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_ACTIVE = 4'h1,
        CMD_READ = 4'h2,
        CMD_WRITE = 4'h3,
        CMD_PRECHARGE = 4'h4,
        CMD_REFRESH = 4'h5,
        CMD_MODE = 4'h6,
        CMD_SELF_ENTER = 4'h7,
        CMD_SELF_EXIT = 4'h8,
        CMD_SUSPEND_ENTER = 4'h9,
        CMD_SUSPEND_EXIT = 4'hA
    } sdcp_cmd_t;

    // SDRAM control pin levels, driven as one group
    typedef struct packed {
        logic memSelN;
        logic rasN;
        logic casN;
        logic writeEnableN;
        logic lowWordMask;
        logic highWordMask;
        logic refreshAddrBit10;
        logic clkEnable;
    } sdcp_pins_t;

    // One command request from the controller
    typedef struct packed {
        sdcp_cmd_t cmd;
        logic [31:0] address;
        logic addrBit10;
        logic wordAccess;
    } sdcp_req_t;
endpackage : sdcp_pkg
`default_nettype wire
